// >>> src/uff_pkg.sv
// Constants for the USB UART flow control block.
// Assumes a 250 MHz core clock; every user writes uff_pkg::name.
package uff_pkg;
  localparam int unsigned CLK_HZ      = 32'h0ee6b280;
  localparam int unsigned DEF_BAUD    = 32'h00002580;
  localparam logic [15:0] DEF_BIT_DIV = 16'(CLK_HZ / DEF_BAUD);
  localparam logic [3:0]  DEF_FRAME   = 4'ha;
  localparam logic [23:0] LL_BAUD     = 24'h00b749;
  localparam logic [10:0] HS_PKT      = 11'h200;
  localparam logic [10:0] FS_PKT      = 11'h040;
  localparam logic [5:0]  IDLE_CHARS  = 6'h03;
  localparam logic [2:0]  FC_OFF      = 3'h0;
  localparam logic [2:0]  FC_HW       = 3'h1;
  localparam logic [2:0]  FC_SW       = 3'h2;
  localparam logic [2:0]  FC_MD3      = 3'h3;
  localparam logic [2:0]  FC_MD4      = 3'h4;
  localparam logic [2:0]  PM_GPIO     = 3'h0;
  localparam logic [2:0]  PM_RTS      = 3'h1;
  localparam logic [2:0]  PM_DTR      = 3'h2;
  localparam logic [2:0]  PM_485      = 3'h3;
  localparam int unsigned PM_POL_BIT  = 3;
  localparam int unsigned FC_HDX_BIT  = 3;
  localparam int unsigned PIN_RX      = 0;
  localparam int unsigned PIN_TX      = 1;
  localparam int unsigned PIN_DSR     = 2;
  localparam int unsigned PIN_DTR     = 3;
  localparam int unsigned PIN_CTS     = 4;
  localparam int unsigned PIN_DIR     = 5;
  localparam int unsigned NUM_PINS    = 8;
endpackage

// >>> src/uff_bit_timer.sv
// Bit-time strobe generator for the flow control block.
// Assumes bit_div holds core clocks per bit and is at least two.
`timescale 1ns/1ps
module uff_bit_timer #(
  parameter int unsigned DIV_W = 16
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Control
  input  wire logic             restart,
  input  wire logic [DIV_W-1:0] bit_div,
  // Strobe, one cycle per bit time
  output logic                  tick
);
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;
  logic             tick_q;
  wire              wrap;

  if (DIV_W < 2)
  begin : g_chk
    $error("uff_bit_timer: DIV_W too small");
  end

  // Restart aligns the first strobe to one full bit after the event.
  assign wrap  = cnt_q >= (bit_div - DIV_W'(1));
  assign cnt_d = (restart || wrap) ? '0 : cnt_q + DIV_W'(1);
  assign tick  = tick_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= wrap && !restart;
    end
  end
endmodule

// >>> src/uff_flow_ctrl.sv
// Receive packet timing and serial line flow control for a USB UART.
// Assumes a receiver that strobes each character and a transmitter
// that raises tx_busy from start bit through last stop bit.
`timescale 1ns/1ps
module uff_flow_ctrl #(
  parameter int unsigned  LVL_W      = 11,
  parameter int unsigned  RX_DEPTH   = 1024,
  parameter logic [10:0]  STOP_LVL   = 11'h3f0,
  parameter logic [10:0]  RESUME_LVL = 11'h3c0
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Bulk-in requests
  input  wire logic             bulkin_req,
  input  wire logic             high_speed,
  input  wire logic [LVL_W-1:0] rx_level,
  output logic                  bulkin_ack,
  output logic                  bulkin_nak,
  output logic [LVL_W-1:0]      bulkin_len,
  // Configuration
  input  wire logic [3:0]       pin_mode,
  input  wire logic [3:0]       flow_mode,
  input  wire logic             low_latency_set,
  input  wire logic             class_driver,
  input  wire logic             line_coding_we,
  input  wire logic [23:0]      line_baud,
  input  wire logic [15:0]      line_bit_div,
  input  wire logic [3:0]       line_frame_bits,
  input  wire logic [7:0]       xon_char,
  input  wire logic [7:0]       xoff_char,
  input  wire logic [3:0]       turnaround_delay_reg,
  // Status
  output logic                  low_latency,
  output logic [15:0]           bit_div,
  output logic [3:0]            frame_bits,
  // Receiver
  input  wire logic             rx_char_valid,
  input  wire logic [8:0]       rx_char_data,
  output logic                  rx_push,
  output logic [8:0]            rx_push_data,
  // Transmitter
  input  wire logic             tx_pending,
  input  wire logic             tx_busy,
  output logic                  tx_allow,
  // Serial pins
  output logic                  direction_pin,
  output logic                  direction_pin_oe,
  output logic                  terminal_ready_pin,
  output logic                  terminal_ready_pin_oe,
  input  wire logic             clear_to_send_pin,
  input  wire logic             set_ready_pin,
  output logic [7:0]            gpio_sel
);
  if (LVL_W < 11 || RX_DEPTH >= (1 << LVL_W) || RESUME_LVL >= STOP_LVL
      || STOP_LVL > RX_DEPTH)
  begin : g_chk
    $error("uff_flow_ctrl: level parameters out of range");
  end

  logic             ack_q, nak_q, ll_auto_q, ll_q, room_q, xoff_q, match_q;
  logic             push_q, allow_q, dir_on_q, busy_q, dpin_q, dpin_oe_q;
  logic             tpin_q, tpin_oe_q;
  logic [LVL_W-1:0] len_q;
  logic [15:0]      div_q;
  logic [3:0]       frame_q, ta_cnt_q, ta_cnt_d;
  logic [5:0]       idle_q, idle_d;
  logic [8:0]       pdata_q;
  logic [7:0]       gsel_q;
  logic             idle_tick, ta_tick;

  // Mode decode.
  wire [2:0] fc      = flow_mode[2:0];
  wire [2:0] pm      = pin_mode[2:0];
  wire       hw_fc   = fc == uff_pkg::FC_HW;
  wire       sw_fc   = fc == uff_pkg::FC_SW;
  wire       md_fc   = fc == uff_pkg::FC_MD3 || fc == uff_pkg::FC_MD4;
  wire       rts_fn  = hw_fc && pm == uff_pkg::PM_RTS;
  wire       dtr_fn  = hw_fc && pm == uff_pkg::PM_DTR;
  wire       rs485   = pm == uff_pkg::PM_485;
  wire       dir_pol = pin_mode[uff_pkg::PM_POL_BIT];
  wire       hdx     = flow_mode[uff_pkg::FC_HDX_BIT];

  // Received character handling.
  wire       take    = rx_char_valid && !(hdx && tx_busy);
  wire       is_addr = rx_char_data[8];
  wire       hit     = rx_char_data[7:0] == xon_char
                    || rx_char_data[7:0] == xoff_char;
  wire       match_d = !md_fc ? 1'b0
                     : (take && is_addr) ? hit : match_q;
  wire       push_d  = take && (!md_fc || (!is_addr && match_q));
  wire       xoff_d  = !sw_fc ? 1'b0
                     : (take && rx_char_data[7:0] == xoff_char) ? 1'b1
                     : (take && rx_char_data[7:0] == xon_char) ? 1'b0
                     : xoff_q;

  // Idle timeout: count bit times since the last kept character.
  wire [5:0] idle_lim = 6'(uff_pkg::IDLE_CHARS * {2'h0, frame_q});
  wire       expired  = idle_q > idle_lim;
  assign idle_d = take ? '0
                : (idle_tick && !expired) ? idle_q + 6'h01 : idle_q;

  // Bulk-in decision.
  wire [LVL_W-1:0] pkt = high_speed ? LVL_W'(uff_pkg::HS_PKT)
                                    : LVL_W'(uff_pkg::FS_PKT);
  wire full     = rx_level >= pkt;
  wire short_ok = rx_level != '0 && (expired || ll_q);
  wire ack_d    = bulkin_req && (full || short_ok);
  wire nak_d    = bulkin_req && !ack_d;
  wire [LVL_W-1:0] len_d = !ack_d ? '0 : full ? pkt : rx_level;

  // Low latency, forced by the class driver at slow rates.
  wire ll_auto_d = (line_coding_we && class_driver)
                 ? line_baud < uff_pkg::LL_BAUD : ll_auto_q;
  wire ll_d      = low_latency_set || ll_auto_d;

  // Receive room with hysteresis so the peer is not toggled per byte.
  wire room_d = rx_level >= LVL_W'(STOP_LVL) ? 1'b0
              : rx_level <= LVL_W'(RESUME_LVL) ? 1'b1 : room_q;

  // Peer pacing: the handshake inputs are active low.
  wire peer_stop = (rts_fn && clear_to_send_pin)
                || (dtr_fn && set_ready_pin);
  // Mode 4 gates the transmitter on the address match; mode 3 never does.
  wire md4_block = fc == uff_pkg::FC_MD4 && !match_q;

  // RS-485 direction and turn-around.
  wire busy_fall = busy_q && !tx_busy;
  assign ta_cnt_d = busy_fall ? turnaround_delay_reg
                  : tx_busy ? 4'h0
                  : (ta_tick && ta_cnt_q != 4'h0) ? ta_cnt_q - 4'h1
                  : ta_cnt_q;
  // The next count is watched too, so the pin does not drop for one cycle
  // while tx_busy falls and the delay has not yet been loaded.
  wire dir_on_d = rs485 && (tx_pending || tx_busy
                || ta_cnt_q != 4'h0
                || ta_cnt_d != 4'h0);
  // Allow rises one cycle after the direction pin and falls with it, so a
  // character is never started on a bus that the block no longer drives.
  wire allow_d  = !peer_stop && !xoff_q && !md4_block
                && (!rs485 || (dir_on_d && dir_on_q));

  // Pin drive.
  wire dpin_d    = rs485 ? (dir_on_d ^ dir_pol)
                 : rts_fn ? !room_d : 1'b1;
  wire dpin_oe_d = rs485 || rts_fn;
  wire tpin_d    = dtr_fn ? !room_d : 1'b1;
  wire tpin_oe_d = dtr_fn;

  // Pins taken by a serial function are not general purpose.
  wire [7:0] func;
  for (genvar i = 0; i < uff_pkg::NUM_PINS; i++)
  begin : g_pin
    if (i == uff_pkg::PIN_RX || i == uff_pkg::PIN_TX)
    begin : g_data
      assign func[i] = 1'b1;
    end
    else if (i == uff_pkg::PIN_DIR)
    begin : g_dir
      assign func[i] = rts_fn || rs485;
    end
    else if (i == uff_pkg::PIN_CTS)
    begin : g_cts
      assign func[i] = rts_fn;
    end
    else if (i == uff_pkg::PIN_DTR || i == uff_pkg::PIN_DSR)
    begin : g_dtr
      assign func[i] = dtr_fn;
    end
    else
    begin : g_gp
      assign func[i] = 1'b0;
    end
  end

  uff_bit_timer #(.DIV_W(16)) u_idle_tmr (
    .clk     (clk),
    .nrst    (nrst),
    .restart (take),
    .bit_div (div_q),
    .tick    (idle_tick)
  );

  uff_bit_timer #(.DIV_W(16)) u_ta_tmr (
    .clk     (clk),
    .nrst    (nrst),
    .restart (busy_fall),
    .bit_div (div_q),
    .tick    (ta_tick)
  );

  // Reset leaves 9600 bps, ten-bit 8N1 frames and low latency off.
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_q   <= uff_pkg::DEF_BIT_DIV;
      frame_q <= uff_pkg::DEF_FRAME;
      ll_auto_q <= 1'b0;
      ll_q    <= 1'b0;
      idle_q  <= '0;
    end
    else
    begin
      div_q   <= line_coding_we ? line_bit_div : div_q;
      frame_q <= line_coding_we ? line_frame_bits : frame_q;
      ll_auto_q <= ll_auto_d;
      ll_q    <= ll_d;
      idle_q  <= idle_d;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack_q <= 1'b0;
      nak_q <= 1'b0;
      len_q <= '0;
    end
    else
    begin
      ack_q <= ack_d;
      nak_q <= nak_d;
      len_q <= len_d;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      match_q <= 1'b0;
      xoff_q  <= 1'b0;
      push_q  <= 1'b0;
      pdata_q <= '0;
      room_q  <= 1'b1;
    end
    else
    begin
      match_q <= match_d;
      xoff_q  <= xoff_d;
      push_q  <= push_d;
      // Push data tracks the input every cycle; it only counts with rx_push.
      pdata_q <= rx_char_data;
      room_q  <= room_d;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_q    <= 1'b0;
      ta_cnt_q  <= 4'h0;
      dir_on_q  <= 1'b0;
      allow_q   <= 1'b0;
      dpin_q    <= 1'b1;
      dpin_oe_q <= 1'b0;
      tpin_q    <= 1'b1;
      tpin_oe_q <= 1'b0;
      gsel_q    <= 8'hfc;
    end
    else
    begin
      busy_q    <= tx_busy;
      ta_cnt_q  <= ta_cnt_d;
      dir_on_q  <= dir_on_d;
      allow_q   <= allow_d;
      dpin_q    <= dpin_d;
      dpin_oe_q <= dpin_oe_d;
      tpin_q    <= tpin_d;
      tpin_oe_q <= tpin_oe_d;
      gsel_q    <= ~func;
    end
  end

  assign bulkin_ack            = ack_q;
  assign bulkin_nak            = nak_q;
  assign bulkin_len            = len_q;
  assign low_latency           = ll_q;
  assign bit_div               = div_q;
  assign frame_bits            = frame_q;
  assign rx_push               = push_q;
  assign rx_push_data          = pdata_q;
  assign tx_allow              = allow_q;
  assign direction_pin         = dpin_q;
  assign direction_pin_oe      = dpin_oe_q;
  assign terminal_ready_pin    = tpin_q;
  assign terminal_ready_pin_oe = tpin_oe_q;
  assign gpio_sel              = gsel_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  full_pkt_ack_a: assert property (bulkin_req && full |=> bulkin_ack
    && bulkin_len == $past(pkt)) else $error("full packet not sent");
  short_nak_a: assert property (bulkin_req && !full && !expired && !ll_q
    |=> bulkin_nak && !bulkin_ack) else $error("short queue acknowledged");
  idle_send_a: assert property (bulkin_req && !full && expired
    && rx_level != '0 |=> bulkin_ack && bulkin_len == $past(rx_level))
    else $error("idle data not sent");
  low_lat_a: assert property (bulkin_req && ll_q && rx_level != '0
    |=> bulkin_ack) else $error("low latency data held");
  auto_ll_a: assert property (line_coding_we && class_driver
    && line_baud < uff_pkg::LL_BAUD |=> ##1 low_latency)
    else $error("slow baud did not force low latency");
  pin_oe_a: assert property (!rts_fn && !rs485 |=> !direction_pin_oe)
    else $error("direction pin driven outside its modes");
  rts_stop_a: assert property (rts_fn && rx_level >= LVL_W'(STOP_LVL)
    |=> direction_pin) else $error("request-to-send kept near overrun");
  cts_halt_a: assert property (rts_fn && clear_to_send_pin
    |=> !tx_allow) else $error("sending while clear-to-send inactive");
  dsr_halt_a: assert property (dtr_fn && set_ready_pin
    |=> !tx_allow) else $error("sending while set-ready inactive");
  xoff_halt_a: assert property (sw_fc && $stable(flow_mode) && take
    && rx_char_data[7:0] == xoff_char |=> ##1 !tx_allow)
    else $error("stop character ignored");
  dir_lead_a: assert property (rs485 && $stable(pin_mode) && tx_allow
    |-> direction_pin != dir_pol) else $error("sending before direction");
  ta_hold_a: assert property (rs485 && $stable(pin_mode)
    && (ta_cnt_q != 4'h0 || ta_cnt_d != 4'h0) |=> direction_pin != dir_pol)
    else $error("direction released during turn-around");
  dir_release_a: assert property (rs485 && $stable(pin_mode) && !tx_pending
    && !tx_busy && ta_cnt_q == 4'h0 && ta_cnt_d == 4'h0
    |=> direction_pin == $past(dir_pol)) else $error("direction not released");
  addr_match_a: assert property (md_fc && take && is_addr
    |=> match_q == $past(hit)) else $error("address match wrong");
  addr_drop_a: assert property (md_fc && rx_char_valid && is_addr
    |=> !rx_push) else $error("address byte stored");
  md4_tx_a: assert property (fc == uff_pkg::FC_MD4 && !match_q
    |=> !tx_allow) else $error("mode 4 sent without match");
  hdx_blank_a: assert property (hdx && tx_busy && rx_char_valid
    |=> !rx_push) else $error("receive not blanked in half duplex");
  data_pins_a: assert property (gpio_sel[1:0] == 2'h0)
    else $error("data pin marked general purpose");

  full_pkt_c: cover property (bulkin_req && full ##1 bulkin_ack);
  idle_pkt_c: cover property (bulkin_req && !full && expired ##1 bulkin_ack);
  ta_c: cover property (rs485 && ta_cnt_q != 4'h0 ##[1:64] ta_cnt_q == 4'h0);
  md_c: cover property (md_fc && take && is_addr && hit ##1 match_q);
  dir_c: cover property (rs485 && tx_pending ##1 direction_pin != dir_pol ##1 tx_allow);
endmodule

// >>> sim/uff_remote_uart.sv
// Behavioural remote UART on the serial side of the flow control block.
// Assumes its tasks are called from the bench's clocked sequence.
`timescale 1ns/1ps
module uff_remote_uart
(
  // Clock
  input  wire logic  clk,
  // Received characters and pacing pins
  output logic       rx_char_valid     = 1'b0,
  output logic [8:0] rx_char_data      = 9'h1aa,
  output logic       clear_to_send_pin = 1'b0,
  output logic       set_ready_pin     = 1'b0
);
  // Data is inverted after the strobe so a stale character never looks fresh.
  task automatic send_char(input logic [8:0] d);
    @(posedge clk);
    rx_char_valid <= 1'b1;
    rx_char_data  <= d;
    @(posedge clk);
    rx_char_valid <= 1'b0;
    rx_char_data  <= ~d;
  endtask

  // Pacing levels are active low, so a high level asks the block to stop.
  task automatic pace(input logic cts_stop, input logic dsr_stop);
    @(posedge clk);
    clear_to_send_pin <= cts_stop;
    set_ready_pin     <= dsr_stop;
  endtask
endmodule

// >>> sim/uff_flow_ctrl_tb.sv
// Self-checking bench for the USB UART flow control block.
// Assumes the remote UART model supplies received characters and pacing pins.
`timescale 1ns/1ps
module uff_flow_ctrl_tb;
  logic        clk = 1'b0, nrst = 1'b0, bulkin_req = 1'b0, high_speed = 1'b0;
  logic        low_latency_set = 1'b0, class_driver = 1'b0, line_coding_we = 1'b0;
  logic        tx_pending = 1'b0, tx_busy = 1'b0;
  logic [10:0] rx_level = 11'h000, bulkin_len;
  logic [3:0]  pin_mode = 4'h0, flow_mode = 4'h0, turnaround_delay_reg = 4'h0;
  logic [3:0]  line_frame_bits = 4'ha, frame_bits;
  logic [23:0] line_baud = 24'h01c200;
  logic [15:0] line_bit_div = 16'h0004, bit_div;
  logic [7:0]  xon_char = 8'h11, xoff_char = 8'h13, gpio_sel;
  logic [8:0]  rx_char_data, rx_push_data;
  logic        bulkin_ack, bulkin_nak, low_latency, rx_push, tx_allow, rx_char_valid;
  logic        direction_pin, direction_pin_oe, terminal_ready_pin, terminal_ready_pin_oe;
  logic        clear_to_send_pin, set_ready_pin;
  int          mismatches = 0, checks = 0;

  uff_flow_ctrl i_uff_flow_ctrl
  (.clk, .nrst, .bulkin_req, .high_speed, .rx_level, .bulkin_ack, .bulkin_nak, .bulkin_len,
   .pin_mode, .flow_mode, .low_latency_set, .class_driver, .line_coding_we, .line_baud,
   .line_bit_div, .line_frame_bits, .xon_char, .xoff_char, .turnaround_delay_reg, .low_latency,
   .bit_div, .frame_bits, .rx_char_valid, .rx_char_data, .rx_push, .rx_push_data, .tx_pending,
   .tx_busy, .tx_allow, .direction_pin, .direction_pin_oe, .terminal_ready_pin,
   .terminal_ready_pin_oe, .clear_to_send_pin, .set_ready_pin, .gpio_sel);
  uff_remote_uart i_uff_remote_uart
  (.clk, .rx_char_valid, .rx_char_data, .clear_to_send_pin, .set_ready_pin);

  always #2 clk = ~clk;

  // The tests need well under two thousand cycles, so this leaves a wide margin.
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end

  task automatic test_done();
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic expect_eq(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic bulk(input logic hs, input logic [10:0] lvl, input logic ack,
                      input logic [10:0] len);
    @(posedge clk);
    high_speed <= hs;
    rx_level   <= lvl;
    bulkin_req <= 1'b1;
    @(posedge clk);
    bulkin_req <= 1'b0;
    #1;
    expect_eq(16'({bulkin_ack, bulkin_nak}), 16'({ack, !ack}), "bulk answer");
    expect_eq(16'(bulkin_len), 16'(len), "bulk length");
  endtask

  task automatic set_line(input logic [23:0] baud);
    @(posedge clk);
    line_baud      <= baud;
    line_coding_we <= 1'b1;
    @(posedge clk);
    line_coding_we <= 1'b0;
    cyc(2);
  endtask

  task automatic cfg(input logic [3:0] pm, input logic [3:0] fm, input logic [10:0] lvl);
    @(posedge clk);
    pin_mode  <= pm;
    flow_mode <= fm;
    rx_level  <= lvl;
    cyc(3);
  endtask

  task automatic rx_chk(input logic [8:0] d, input logic pushed);
    i_uff_remote_uart.send_char(d);
    #1;
    expect_eq(16'(rx_push), 16'(pushed), "push");
    if (pushed)
      expect_eq(16'(rx_push_data), 16'(d), "push data");
  endtask

  task automatic pace_chk(input logic cts, input logic dsr, input logic allow);
    i_uff_remote_uart.pace(cts, dsr);
    cyc(3);
    expect_eq(16'(tx_allow), 16'(allow), "pacing");
  endtask

  task automatic test_reset_state();
    expect_eq(16'(gpio_sel), 16'h00fc, "data pins not gpio");
    expect_eq(bit_div, 16'(uff_pkg::DEF_BIT_DIV), "baud default");
    expect_eq(16'(frame_bits), 16'(uff_pkg::DEF_FRAME), "frame default");
  endtask

  task automatic test_bulk_full();
    bulk(1'b1, 11'h258, 1'b1, 11'h200);
    bulk(1'b0, 11'h040, 1'b1, 11'h040);
    bulk(1'b0, 11'h03f, 1'b0, 11'h000);
  endtask

  // Idle expiry needs more than thirty bit ticks after the last character.
  task automatic test_idle();
    set_line(24'h01c200);
    expect_eq(bit_div, 16'h0004, "bit divider load");
    rx_chk(9'h041, 1'b1);
    cyc(95);
    bulk(1'b0, 11'h00a, 1'b0, 11'h000);
    cyc(50);
    bulk(1'b0, 11'h00a, 1'b1, 11'h00a);
  endtask

  task automatic test_low_latency();
    @(posedge clk);
    low_latency_set <= 1'b1;
    rx_chk(9'h042, 1'b1);
    bulk(1'b0, 11'h005, 1'b1, 11'h005);
    @(posedge clk);
    low_latency_set <= 1'b0;
    class_driver    <= 1'b1;
    set_line(24'h00b748);
    expect_eq(16'(low_latency), 16'h0001, "auto low latency");
    set_line(24'h00b749);
    expect_eq(16'(low_latency), 16'h0000, "no auto low latency");
  endtask

  task automatic test_hw_handshake();
    @(posedge clk);
    tx_pending <= 1'b1;
    cfg(4'h1, 4'h1, 11'h3f0);
    expect_eq(16'({direction_pin, direction_pin_oe}), 16'h0003, "rts dropped");
    cfg(4'h1, 4'h1, 11'h3c0);
    expect_eq(16'(direction_pin), 16'h0000, "rts restored");
    expect_eq(16'(gpio_sel), 16'h00cc, "rts pins taken");
    pace_chk(1'b1, 1'b0, 1'b0);
    cfg(4'h0, 4'h1, 11'h000);
    expect_eq(16'(tx_allow), 16'h0001, "cts unused");
    cfg(4'h1, 4'h1, 11'h000);
    expect_eq(16'(tx_allow), 16'h0000, "cts used");
    pace_chk(1'b0, 1'b0, 1'b1);
  endtask

  task automatic test_dtr_handshake();
    cfg(4'h2, 4'h1, 11'h3f0);
    expect_eq(16'({terminal_ready_pin, terminal_ready_pin_oe}), 16'h0003, "dtr dropped");
    cfg(4'h2, 4'h1, 11'h3c0);
    expect_eq(16'(terminal_ready_pin), 16'h0000, "dtr restored");
    expect_eq(16'(gpio_sel), 16'h00f0, "dtr pins taken");
    pace_chk(1'b0, 1'b1, 1'b0);
    pace_chk(1'b0, 1'b0, 1'b1);
  endtask

  task automatic test_sw_flow();
    cfg(4'h0, 4'h2, 11'h000);
    rx_chk(9'h013, 1'b1);
    cyc(3);
    expect_eq(16'(tx_allow), 16'h0000, "stop char");
    rx_chk(9'h011, 1'b1);
    cyc(3);
    expect_eq(16'(tx_allow), 16'h0001, "resume char");
  endtask

  // Release after two bit times of four clocks lands about ten clocks after busy falls.
  task automatic test_rs485();
    @(posedge clk);
    tx_pending           <= 1'b0;
    turnaround_delay_reg <= 4'h2;
    cfg(4'h3, 4'h0, 11'h000);
    @(posedge clk);
    tx_pending <= 1'b1;
    cyc(1);
    expect_eq(16'({direction_pin, tx_allow}), 16'h0002, "direction first");
    cyc(1);
    expect_eq(16'(tx_allow), 16'h0001, "send after direction");
    @(posedge clk);
    tx_busy    <= 1'b1;
    tx_pending <= 1'b0;
    repeat (10) @(posedge clk);
    tx_busy <= 1'b0;
    cyc(4);
    expect_eq(16'(direction_pin), 16'h0001, "direction held");
    cyc(12);
    expect_eq(16'(direction_pin), 16'h0000, "direction released");
    cfg(4'hb, 4'h0, 11'h000);
    expect_eq(16'(direction_pin), 16'h0001, "direction inverted");
  endtask

  task automatic test_multidrop();
    @(posedge clk);
    tx_pending <= 1'b1;
    cfg(4'h0, 4'h4, 11'h000);
    expect_eq(16'(tx_allow), 16'h0000, "mode 4 unmatched");
    rx_chk(9'h055, 1'b0);
    rx_chk(9'h111, 1'b0);
    rx_chk(9'h0aa, 1'b1);
    cyc(2);
    expect_eq(16'(tx_allow), 16'h0001, "mode 4 matched");
    rx_chk(9'h1ff, 1'b0);
    rx_chk(9'h0bb, 1'b0);
    cfg(4'h0, 4'h3, 11'h000);
    expect_eq(16'(tx_allow), 16'h0001, "mode 3 free");
    rx_chk(9'h113, 1'b0);
    rx_chk(9'h0cc, 1'b1);
  endtask

  task automatic test_half_duplex();
    cfg(4'h0, 4'h8, 11'h000);
    @(posedge clk);
    tx_busy <= 1'b1;
    rx_chk(9'h033, 1'b0);
    @(posedge clk);
    tx_busy <= 1'b0;
    rx_chk(9'h034, 1'b1);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    #1;
    test_reset_state();
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    test_bulk_full();
    test_idle();
    test_low_latency();
    test_hw_handshake();
    test_dtr_handshake();
    test_sw_flow();
    test_rs485();
    test_multidrop();
    test_half_duplex();
    test_done();
  end
endmodule
